// >>> bgn_map.svh
// timing constants for the buck gate non-overlap control block
`ifndef BGN_MAP_SVH
`define BGN_MAP_SVH
// -------------------------------------------------------------
// clock and dead-time figures
// -------------------------------------------------------------
`define BGN_CLK_PERIOD_PS    10000
`define BGN_FALLBACK_PS      120000
`define BGN_TIMEOUT_PS       240000
`define BGN_UPPER_DELAY_PS   40000
// least times round up to whole cycles
`define BGN_FALLBACK_CYC ((`BGN_FALLBACK_PS + `BGN_CLK_PERIOD_PS - 1) / `BGN_CLK_PERIOD_PS)
`define BGN_TIMEOUT_CYC  ((`BGN_TIMEOUT_PS + `BGN_CLK_PERIOD_PS - 1) / `BGN_CLK_PERIOD_PS)
`define BGN_UPPER_CYC    ((`BGN_UPPER_DELAY_PS + `BGN_CLK_PERIOD_PS - 1) / `BGN_CLK_PERIOD_PS)
`define BGN_CNT_W        8
`endif

// >>> bgn_pkg.sv
// types for the buck gate non-overlap control block
package bgn_pkg;
  // -------------------------------------------------------------
  // sequencer states
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    BGN_IDLE,
    BGN_UPPER_WAIT,
    BGN_UPPER_ON,
    BGN_LOWER_WAIT,
    BGN_LOWER_ON
  } bgn_state_t;
  // comparator flags carried together
  typedef struct packed {
    logic node_high;
    logic node_below_1v;
    logic lower_below_thr;
  } bgn_sense_t;
  // gate command pair
  typedef struct packed {
    logic upper;
    logic lower;
  } bgn_gates_t;
endpackage

// >>> bgn_delay_cnt.sv
// down counter measuring the fixed 40 ns upper dead-time delay
module bgn_delay_cnt #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // control
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  // state
  output logic      [W-1:0] count_out
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  // -------------------------------------------------------------
  // next count: load wins, otherwise count down to zero
  // -------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = value_in;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  assign count_out = count;
endmodule

// >>> bgn_gate_ctrl.sv
// non-overlap sequencer for the upper and lower gate commands
// -------------------------------------------------------------
// -------------------------------------------------------------
`include "bgn_map.svh"
module bgn_gate_ctrl #(
  parameter int CNT_W = `BGN_CNT_W
) (
  // clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               rst_in,
  // controller side
  input  wire logic               pwm_in,
  input  wire logic               output_disable_n_in,
  // comparator flags, already synchronous
  input  wire bgn_pkg::bgn_sense_t sense_in,
  // gate commands
  output logic                    upper_gate_cmd_out,
  output logic                    lower_gate_cmd_out
);
  // -------------------------------------------------------------
  // delay constants in cycles
  // -------------------------------------------------------------
  localparam logic [CNT_W-1:0] FALLBACK_CYC = CNT_W'(`BGN_FALLBACK_CYC);
  localparam logic [CNT_W-1:0] TIMEOUT_CYC  = CNT_W'(`BGN_TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] UPPER_CYC    = CNT_W'(`BGN_UPPER_CYC);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  bgn_pkg::bgn_state_t state;            // sequencer state
  bgn_pkg::bgn_state_t next_state;
  bgn_pkg::bgn_gates_t gates;            // registered commands
  bgn_pkg::bgn_gates_t next_gates;
  logic                seen_high;        // node seen high since upper release
  logic                next_seen_high;
  logic                below_seen;       // lower gate under threshold, delay armed
  logic                next_below_seen;
  logic [CNT_W-1:0]    elapsed;          // cycles since upper released
  logic [CNT_W-1:0]    next_elapsed;
  logic                cnt_load;         // restart the delay counter
  logic [CNT_W-1:0]    cnt_value;
  logic [CNT_W-1:0]    cnt;              // remaining delay cycles
  logic                enabled;

  assign enabled = output_disable_n_in;

  // -------------------------------------------------------------
  // delay counter used only for the 40 ns upper delay
  // -------------------------------------------------------------
  bgn_delay_cnt #(
    .W (CNT_W)
  ) u_delay (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .load_in    (cnt_load),
    .value_in   (cnt_value),
    .count_out  (cnt)
  );

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_gates      = gates;
    next_seen_high  = seen_high;
    next_below_seen = below_seen;
    next_elapsed    = elapsed;
    cnt_load        = 1'b0;
    cnt_value       = UPPER_CYC;
    if (!enabled) begin
      // disable overrides everything, both gates off at once
      next_state      = bgn_pkg::BGN_IDLE;
      next_gates      = '0;
      next_seen_high  = 1'b0;
      next_below_seen = 1'b0;
      next_elapsed    = '0;
    end else begin
      case (state)
        // coming out of disable: pick side from the pulse level
        bgn_pkg::BGN_IDLE: begin
          next_gates = '0;
          if (pwm_in) begin
            next_state = bgn_pkg::BGN_UPPER_WAIT;
          end else begin
            next_state   = bgn_pkg::BGN_LOWER_WAIT;
            next_elapsed = '0;
            next_seen_high = 1'b0;
          end
        end
        // lower released, wait for its level then 40 ns
        bgn_pkg::BGN_UPPER_WAIT: begin
          next_gates.lower = 1'b0;
          if (!pwm_in) begin
            next_state     = bgn_pkg::BGN_LOWER_ON;
            next_gates     = 2'b01;
            next_below_seen = 1'b0;
          end else if (!below_seen) begin
            if (sense_in.lower_below_thr && !gates.lower) begin
              next_below_seen = 1'b1;
              cnt_load        = 1'b1;
            end
          end else if (cnt == '0) begin
            next_state      = bgn_pkg::BGN_UPPER_ON;
            next_gates      = 2'b10;
            next_below_seen = 1'b0;
          end
        end
        // upper conducting until the pulse falls
        bgn_pkg::BGN_UPPER_ON: begin
          if (!pwm_in) begin
            next_state     = bgn_pkg::BGN_LOWER_WAIT;
            next_gates     = '0;
            next_seen_high = 1'b0;
            next_elapsed   = '0;
          end
        end
        // upper released: watch the switch node
        bgn_pkg::BGN_LOWER_WAIT: begin
          next_gates.upper = 1'b0;
          if (elapsed != TIMEOUT_CYC) begin
            next_elapsed = elapsed + 1'b1;
          end
          if (sense_in.node_high) begin
            next_seen_high = 1'b1;
          end
          if (pwm_in) begin
            // pulse back up before lower came on: lower already off
            next_state      = bgn_pkg::BGN_UPPER_WAIT;
            next_below_seen = 1'b0;
          end else if (seen_high && sense_in.node_below_1v) begin
            next_state = bgn_pkg::BGN_LOWER_ON;
            next_gates = 2'b01;
          end else if (!seen_high && !sense_in.node_high
                       && elapsed >= FALLBACK_CYC) begin
            next_state = bgn_pkg::BGN_LOWER_ON;
            next_gates = 2'b01;
          end else if (elapsed >= TIMEOUT_CYC) begin
            // reverse inductor current holds the node up
            next_state = bgn_pkg::BGN_LOWER_ON;
            next_gates = 2'b01;
          end
        end
        // lower conducting until the pulse rises
        bgn_pkg::BGN_LOWER_ON: begin
          if (pwm_in) begin
            next_state      = bgn_pkg::BGN_UPPER_WAIT;
            next_gates      = '0;
            next_below_seen = 1'b0;
          end
        end
        default: begin
          next_state = bgn_pkg::BGN_IDLE;
          next_gates = '0;
        end
      endcase
    end
    // last guard: one gate at most, upper dropped if both asked
    if (next_gates.upper && next_gates.lower) begin
      next_gates.upper = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state      <= bgn_pkg::BGN_IDLE;
      gates      <= '0;
      seen_high  <= 1'b0;
      below_seen <= 1'b0;
      elapsed    <= '0;
    end else begin
      state      <= next_state;
      gates      <= next_gates;
      seen_high  <= next_seen_high;
      below_seen <= next_below_seen;
      elapsed    <= next_elapsed;
    end
  end

  assign upper_gate_cmd_out = gates.upper;
  assign lower_gate_cmd_out = gates.lower;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_no_overlap;
    @(posedge clk_sys_in) disable iff (rst_in)
      !(upper_gate_cmd_out && lower_gate_cmd_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gates on");

  property p_dis_both_low;
    @(posedge clk_sys_in) disable iff (rst_in)
      !output_disable_n_in |=> !upper_gate_cmd_out && !lower_gate_cmd_out;
  endproperty
  a_dis_both_low: assert property (p_dis_both_low)
    else $error("gates on while disabled");

  property p_dis_lower;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(lower_gate_cmd_out) |-> $past(output_disable_n_in);
  endproperty
  a_dis_lower: assert property (p_dis_lower)
    else $error("lower on after disable");

  property p_dis_upper;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(upper_gate_cmd_out) |-> $past(output_disable_n_in);
  endproperty
  a_dis_upper: assert property (p_dis_upper)
    else $error("upper on after disable");

  property p_upper_needs_pwm;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(upper_gate_cmd_out) |-> $past(pwm_in);
  endproperty
  a_upper_needs_pwm: assert property (p_upper_needs_pwm)
    else $error("upper on without pulse");

  property p_lower_needs_low_pwm;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(lower_gate_cmd_out) |-> !$past(pwm_in);
  endproperty
  a_lower_needs_low_pwm: assert property (p_lower_needs_low_pwm)
    else $error("lower on with pulse high");

  property p_upper_delay;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(upper_gate_cmd_out) |-> $past(below_seen) && $past(cnt) == '0
        && !$past(lower_gate_cmd_out, 4);
  endproperty
  a_upper_delay: assert property (p_upper_delay)
    else $error("upper on before 40 ns delay");

  property p_pwm_rise_release;
    @(posedge clk_sys_in) disable iff (rst_in)
      output_disable_n_in && pwm_in && lower_gate_cmd_out |=> !lower_gate_cmd_out;
  endproperty
  a_pwm_rise_release: assert property (p_pwm_rise_release)
    else $error("lower not released on pulse rise");

  property p_lower_timeout;
    @(posedge clk_sys_in) disable iff (rst_in)
      state == bgn_pkg::BGN_LOWER_WAIT && output_disable_n_in && !pwm_in
        && elapsed >= TIMEOUT_CYC |=> lower_gate_cmd_out;
  endproperty
  a_lower_timeout: assert property (p_lower_timeout)
    else $error("lower not on at timeout");

  property p_lower_fallback;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(lower_gate_cmd_out) && $past(state) == bgn_pkg::BGN_LOWER_WAIT
        && !$past(seen_high) && !$past(sense_in.node_high)
        |-> $past(elapsed) >= FALLBACK_CYC;
  endproperty
  a_lower_fallback: assert property (p_lower_fallback)
    else $error("lower on before fallback delay");

  property p_lower_sw;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(lower_gate_cmd_out) && $past(state) == bgn_pkg::BGN_LOWER_WAIT
        && $past(seen_high) && $past(elapsed) < TIMEOUT_CYC
        |-> $past(sense_in.node_below_1v);
  endproperty
  a_lower_sw: assert property (p_lower_sw)
    else $error("lower on with node still high");

  // upper must drop one edge after the pulse is seen low
  property p_upper_follows;
    @(posedge clk_sys_in) disable iff (rst_in)
      output_disable_n_in && !pwm_in |=> !upper_gate_cmd_out;
  endproperty
  a_upper_follows: assert property (p_upper_follows)
    else $error("upper still on with pulse low");

  // lower must drop one edge after the pulse is seen high
  property p_lower_follows;
    @(posedge clk_sys_in) disable iff (rst_in)
      output_disable_n_in && pwm_in |=> !lower_gate_cmd_out;
  endproperty
  a_lower_follows: assert property (p_lower_follows)
    else $error("lower still on with pulse high");

  // disable parks the sequencer so a restart always re-qualifies both sides
  property p_dis_idle;
    @(posedge clk_sys_in) disable iff (rst_in)
      !output_disable_n_in |=> state == bgn_pkg::BGN_IDLE;
  endproperty
  a_dis_idle: assert property (p_dis_idle)
    else $error("sequencer not parked while disabled");
endmodule

// >>> bgn_stage_model.sv
// behavioural power stage giving the switch node and lower gate flags
module bgn_stage_model (
  // clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  // gate commands from the block
  input  wire logic                upper_cmd_in,
  input  wire logic                lower_cmd_in,
  // behaviour: 0 normal, 1 node never rises, 2 node held high
  input  wire logic [1:0]          mode_in,
  input  wire logic [4:0]          dly_in,
  // comparator flags
  output bgn_pkg::bgn_sense_t      sense_out
);
  // -------------------------------------------------------------
  // node and gate state
  // -------------------------------------------------------------
  logic       node_hi;  // switch node above 1 V
  logic [4:0] ncnt;     // node fall countdown
  logic [4:0] lcnt;     // lower gate drain countdown
  // lower switch pulls the node down; negative current can hold it up
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      node_hi <= 1'b0;
      ncnt    <= 5'h00;
      lcnt    <= 5'h00;
    end else begin
      lcnt <= lower_cmd_in ? dly_in : ((lcnt != 5'h00) ? lcnt - 5'h01 : lcnt);
      if (upper_cmd_in) begin
        node_hi <= (mode_in != 2'h1);
        ncnt    <= dly_in;
      end else if (lower_cmd_in) begin
        node_hi <= 1'b0;
      end else if (ncnt != 5'h00) begin
        ncnt <= ncnt - 5'h01;
      end else if (mode_in != 2'h2) begin // held high models body diode current
        node_hi <= 1'b0;
      end
    end
  end
  // flags change only on the clock, as the block expects
  assign sense_out.node_high       = node_hi;
  assign sense_out.node_below_1v   = ~node_hi;
  assign sense_out.lower_below_thr = ~lower_cmd_in & (lcnt == 5'h00);
endmodule

// >>> buck_gate_nonoverlap_control_bench.sv
// self-checking bench for the gate non-overlap sequencer
module buck_gate_nonoverlap_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // stimulus and observation
  // -------------------------------------------------------------
  logic                clk_sys_in;
  logic                rst_in;
  logic                pwm_in;
  logic                output_disable_n;  // active-low disable
  logic [1:0]          mode;              // stage behaviour
  logic [4:0]          dly;               // stage slowness in cycles
  bgn_pkg::bgn_sense_t sense;
  logic                upper;
  logic                lower;
  int                  miscompares;
  int                  num_checks;
  int                  cyc;
  // rows: pwm, enable, expected upper, expected lower
  logic [3:0]          rows [6] = '{4'hE, 4'h5, 4'h8, 4'h0, 4'hE, 4'h5};

  bgn_gate_ctrl uut (
    .clk_sys_in          (clk_sys_in),
    .rst_in              (rst_in),
    .pwm_in              (pwm_in),
    .output_disable_n_in (output_disable_n),
    .sense_in            (sense),
    .upper_gate_cmd_out  (upper),
    .lower_gate_cmd_out  (lower)
  );
  bgn_stage_model stage (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .upper_cmd_in (upper),
    .lower_cmd_in (lower),
    .mode_in      (mode),
    .dly_in       (dly),
    .sense_out    (sense)
  );
  // -------------------------------------------------------------
  // clock, watchdog and shoot-through watch
  // -------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // a hang counts as a mismatch
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(negedge clk_sys_in) if (!rst_in) check({31'h0, upper & lower}, 32'h0);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cycles until a gate reads high, bounded so a stuck gate still ends
  task automatic count_rise(input bit up, output int n);
    n = 0;
    while (((up ? upper : lower) !== 1'b1) && n < 60) begin
      @(negedge clk_sys_in);
      n++;
    end
  endtask
  // upper off, then time the lower turn-on against a window
  task automatic lower_on(input logic [1:0] m, input logic [4:0] d, input int lo, input int hi);
    int n;
    @(posedge clk_sys_in);
    mode   <= m;
    dly    <= d;
    pwm_in <= 1'b1;
    repeat (100) @(posedge clk_sys_in); // half period keeps 500 kHz at most
    pwm_in <= 1'b0;
    @(negedge clk_sys_in);
    while (upper !== 1'b0) @(negedge clk_sys_in);
    count_rise(1'b0, n);
    check({31'h0, n >= lo && n <= hi}, 32'h1);
    repeat (100) @(posedge clk_sys_in);
  endtask
  // lower off, threshold seen, then the fixed upper delay
  task automatic upper_on(input logic [4:0] d);
    int n;
    @(posedge clk_sys_in);
    mode   <= 2'h0;
    dly    <= d;
    pwm_in <= 1'b0;
    repeat (100) @(posedge clk_sys_in);
    pwm_in <= 1'b1;
    @(negedge clk_sys_in);
    while (sense.lower_below_thr !== 1'b1) @(negedge clk_sys_in);
    check({31'h0, upper}, 32'h0);
    count_rise(1'b1, n);
    check({31'h0, n >= 4 && n <= 7}, 32'h1);
    repeat (100) @(posedge clk_sys_in);
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst_in           = 1'b1;
    pwm_in           = 1'b0;
    output_disable_n = 1'b1;
    mode             = 2'h0;
    dly              = 5'h02;
    repeat (6) @(posedge clk_sys_in);
    check({30'h0, upper, lower}, 32'h0);
    rst_in <= 1'b0;
    // steady levels, enabled and disabled
    foreach (rows[i]) begin
      pwm_in           <= rows[i][3];
      output_disable_n <= rows[i][2];
      repeat (100) @(posedge clk_sys_in);
      check({30'h0, upper, lower}, {30'h0, rows[i][1:0]});
    end
    lower_on(2'h0, 5'h03, 4, 7);
    lower_on(2'h0, 5'h0F, 16, 19);
    lower_on(2'h1, 5'h03, 12, 14);
    lower_on(2'h2, 5'h03, 24, 26);
    upper_on(5'h00);
    upper_on(5'h06);
    // disable while the timeout is still running
    @(posedge clk_sys_in);
    mode   <= 2'h2;
    pwm_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    output_disable_n <= 1'b0;
    repeat (2) @(negedge clk_sys_in);
    repeat (100) begin
      @(negedge clk_sys_in);
      check({30'h0, upper, lower}, 32'h0);
    end
    // reset in mid-run with the upper gate on
    @(posedge clk_sys_in);
    output_disable_n <= 1'b1;
    pwm_in           <= 1'b1;
    repeat (100) @(posedge clk_sys_in);
    check({31'h0, upper}, 32'h1);
    rst_in <= 1'b1;
    #1;
    check({30'h0, upper, lower}, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (100) @(posedge clk_sys_in);
    check({30'h0, upper, lower}, 32'h2);
    end_sim();
  end
endmodule
